/* File: core/lookahead_rx_pkg.sv */
// Constants, types and register map of the look-ahead receive descriptor engine
package lookahead_rx_pkg;

    // ************************************************************
    // Ring geometry and widths
    // ************************************************************
    localparam int RING_LEN  = 9;          // Three groups of three descriptors
    localparam int GROUP_LEN = 3;
    localparam int IDX_W     = 4;
    localparam int SIZE_W    = 11;
    localparam int ADDR_W    = 8;

    typedef logic [IDX_W-1:0]  ringIdx_t;
    typedef logic [SIZE_W-1:0] bufCnt_t;
    typedef logic [31:0]       descWord_t;
    typedef logic [1:0]        grpPos_t;

    localparam grpPos_t POS_FIRST = 2'h0;
    localparam grpPos_t POS_LAST  = 2'h2;

    // ************************************************************
    // Descriptor word layout
    // ************************************************************
    localparam int DESC_OWN_BIT   = 31;    // 1: owned by the engine
    localparam int DESC_START_BIT = 30;    // frameStartFlag
    localparam int DESC_END_BIT   = 29;    // frameEndFlag
    localparam int DESC_ERR_BIT   = 28;
    localparam int DESC_SIZE_LSB  = 0;
    localparam descWord_t DESC_RESET = 32'h0000_0000;

    // ************************************************************
    // Register map (byte offsets on the bus)
    // ************************************************************
    localparam logic [ADDR_W-1:0] REG_CTRL_OFS   = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_DESC_BASE  = 8'h40;
    localparam int CTRL_ENABLE_BIT = 0;    // lookaheadRxEnable
    localparam logic CTRL_ENABLE_RESET = 1'b0;
    localparam int STAT_IDX_LSB    = 0;
    localparam int STAT_STATE_LSB  = 8;
    localparam int STAT_FRAMES_LSB = 16;
    localparam logic [15:0] FRAMES_RESET = 16'h0000;

    // ************************************************************
    // Engine states
    // ************************************************************
    typedef enum logic [4:0] {
        ST_SEARCH  = 5'b0_0001,
        ST_FILL    = 5'b0_0010,
        ST_CLOSE   = 5'b0_0100,
        ST_RELEASE = 5'b0_1000,
        ST_DROP    = 5'b1_0000
    } engState_t;

endpackage

/* File: core/desc_ring_store.sv */
// Descriptor ring storage with software and engine write ports
`timescale 1ns/1ps
module desc_ring_store
    import lookahead_rx_pkg::*;
(
    input  wire logic                                 clk,
    input  wire logic                                 rst_n,
    input  wire logic                                 swWrEn,
    input  wire lookahead_rx_pkg::ringIdx_t           swWrIdx,
    input  wire lookahead_rx_pkg::descWord_t          swWrData,
    input  wire logic                                 engWrEn,
    input  wire lookahead_rx_pkg::ringIdx_t           engWrIdx,
    input  wire lookahead_rx_pkg::descWord_t          engWrData,
    output lookahead_rx_pkg::descWord_t [RING_LEN-1:0] ring
);
    import lookahead_rx_pkg::*;

    // ************************************************************
    // One flip-flop word per entry
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < RING_LEN; gi++) begin : gEntry
            wire logic engHit = engWrEn && (engWrIdx == ringIdx_t'(gi));
            wire logic swHit  = swWrEn && (swWrIdx == ringIdx_t'(gi));
            // Engine write wins: it only touches words it owns
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    ring[gi] <= DESC_RESET;
                end else if (engHit) begin
                    ring[gi] <= engWrData;
                end else if (swHit) begin
                    ring[gi] <= swWrData;
                end
            end
        end
    endgenerate

endmodule

/* File: core/lookahead_rx_engine.sv */
// Look-ahead receive descriptor engine with AHB-Lite register slave
// Functional notes
// - Fill group buffers in order, flag each one
// - Park owned at next group start, untouched
// - Frame ending in buffer two: flag there
// - Owned third descriptor released with own, start and end bits zeroed, error bit kept
// - Unowned third descriptor skipped, end flag untouched
// - Frame in buffer one releases second descriptor
// - New frame only in owned start descriptor
// - Search discards owned non-start, skips unowned non-start
`timescale 1ns/1ps
module lookahead_rx_engine
    import lookahead_rx_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic                             hreadyout,
    output logic                             hresp,
    output logic [31:0]                      hrdata,
    input  wire logic                        rxValid,
    input  wire logic [7:0]                  rxData,
    input  wire logic                        rxLast,
    input  wire logic                        rxErr,
    output logic                             rxReady,
    output logic                             bufWrValid,
    output lookahead_rx_pkg::ringIdx_t       bufWrIdx,
    output lookahead_rx_pkg::bufCnt_t        bufWrOffset,
    output logic [7:0]                       bufWrData
);
    import lookahead_rx_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    engState_t                  state_q, state_d;
    ringIdx_t                   curIdx_q, curIdx_d;
    bufCnt_t                    cnt_q, cnt_d;
    logic                       endF_q, endF_d;
    logic                       errF_q, errF_d;
    logic [15:0]                frames_q, frames_d;
    logic                       enable_q;
    logic                       dpWr_q;
    logic [ADDR_W-1:0]          dpAddr_q;
    logic [31:0]                rdata_q;
    logic                       engWrEn;
    descWord_t                  engWrData;
    descWord_t [RING_LEN-1:0]   ring;

    // ************************************************************
    // Address decode helpers
    // ************************************************************
    function automatic logic descHit(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off = a - REG_DESC_BASE;
        descHit = (a >= REG_DESC_BASE) && (a[1:0] == 2'b00)
                  && (off[ADDR_W-1:2] < (ADDR_W-2)'(RING_LEN));
    endfunction

    function automatic ringIdx_t descIdx(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off = a - REG_DESC_BASE;
        descIdx = off[IDX_W+1:2];
    endfunction

    // ************************************************************
    // Ring walk helpers
    // ************************************************************
    wire ringIdx_t  nextIdx  = (curIdx_q == ringIdx_t'(RING_LEN - 1)) ? '0 : curIdx_q + 1'b1;
    wire grpPos_t   curPos   = grpPos_t'(curIdx_q % ringIdx_t'(GROUP_LEN));
    wire descWord_t curDesc  = ring[curIdx_q];
    wire descWord_t nextDesc = ring[nextIdx];
    wire logic      curOwn   = curDesc[DESC_OWN_BIT];
    wire logic      curStart = curDesc[DESC_START_BIT];
    wire bufCnt_t   curSize  = curDesc[DESC_SIZE_LSB +: SIZE_W];
    wire bufCnt_t   cntInc   = cnt_q + 1'b1;
    wire logic      ended    = endF_q || errF_q;
    // Continue into the next buffer only inside the group and if it is ours
    wire logic      canChain = (curPos != POS_LAST) && nextDesc[DESC_OWN_BIT];

    // ************************************************************
    // Bus slave decode
    // ************************************************************
    wire logic          addrPhase = hsel && htrans[1] && hready;
    wire logic [ADDR_W-1:0] aAddr = haddr[ADDR_W-1:0];
    wire logic          swDescWr  = dpWr_q && descHit(dpAddr_q);
    wire logic          ctrlWr    = dpWr_q && (dpAddr_q == REG_CTRL_OFS);
    wire logic          fwdHit    = dpWr_q && (dpAddr_q == aAddr);
    wire logic [31:0]   ctrlRead  = {31'h0000_0000, enable_q};
    wire logic [31:0]   statRead  = {frames_q, 3'h0, state_q, 4'h0, curIdx_q};
    wire logic [31:0]   descRead  = ring[descIdx(aAddr)];
    wire logic [31:0]   rdMux     = (aAddr == REG_CTRL_OFS)   ? ctrlRead :
                                    (aAddr == REG_STATUS_OFS) ? statRead :
                                    descHit(aAddr)            ? descRead : 32'h0000_0000;
    // A write in its data phase is forwarded to a read of the same word
    wire logic [31:0]   rdValue   = (fwdHit && aAddr == REG_CTRL_OFS) ?
                                        {31'h0000_0000, hwdata[CTRL_ENABLE_BIT]} :
                                    (fwdHit && descHit(aAddr)) ? hwdata : rdMux;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;

    // Address phase capture and read data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dpWr_q   <= 1'b0;
            dpAddr_q <= '0;
            rdata_q  <= 32'h0000_0000;
        end else begin
            dpWr_q   <= addrPhase && hwrite;
            dpAddr_q <= aAddr;
            if (addrPhase && !hwrite) begin
                rdata_q <= rdValue;
            end
        end
    end

    // Control register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enable_q <= CTRL_ENABLE_RESET;
        end else if (ctrlWr) begin
            enable_q <= hwdata[CTRL_ENABLE_BIT];
        end
    end

    // ************************************************************
    // Descriptor storage
    // ************************************************************
    desc_ring_store uRing (
        .clk       (clk),
        .rst_n     (rst_n),
        .swWrEn    (swDescWr),
        .swWrIdx   (descIdx(dpAddr_q)),
        .swWrData  (hwdata),
        .engWrEn   (engWrEn),
        .engWrIdx  (curIdx_q),
        .engWrData (engWrData),
        .ring      (ring)
    );

    // ************************************************************
    // Engine state machine
    // ************************************************************
    always_comb begin
        state_d   = state_q;
        curIdx_d  = curIdx_q;
        cnt_d     = cnt_q;
        endF_d    = endF_q;
        errF_d    = errF_q;
        frames_d  = frames_q;
        engWrEn   = 1'b0;
        engWrData = curDesc;
        case (state_q)
            ST_SEARCH: begin
                if (enable_q) begin
                    if (curOwn && curStart) begin
                        cnt_d   = '0;
                        state_d = ST_FILL;
                    end else if (curOwn) begin
                        engWrEn = 1'b1;
                        engWrData[DESC_OWN_BIT] = 1'b0;
                        curIdx_d = nextIdx;
                    end else if (!curStart) begin
                        curIdx_d = nextIdx;
                    end
                end
            end
            ST_FILL: begin
                if (rxValid) begin
                    cnt_d = cntInc;
                    if (rxLast) begin
                        endF_d  = !rxErr;
                        errF_d  = rxErr;
                        state_d = ST_CLOSE;
                    end else if (cntInc == curSize) begin
                        endF_d  = 1'b0;
                        errF_d  = 1'b0;
                        state_d = ST_CLOSE;
                    end
                end
            end
            ST_CLOSE: begin
                // Status lands one cycle after the last byte of the buffer
                engWrEn = 1'b1;
                engWrData[DESC_OWN_BIT] = 1'b0;
                engWrData[DESC_END_BIT] = endF_q;
                engWrData[DESC_ERR_BIT] = errF_q || (!ended && !canChain);
                curIdx_d = nextIdx;
                if (ended) begin
                    frames_d = frames_q + 1'b1;
                    state_d  = ST_RELEASE;
                end else if (canChain) begin
                    cnt_d   = '0;
                    state_d = ST_FILL;
                end else begin
                    frames_d = frames_q + 1'b1;
                    state_d  = ST_DROP;
                end
            end
            ST_RELEASE: begin
                if (curPos == POS_FIRST) begin
                    state_d = ST_SEARCH;
                end else if (curOwn) begin
                    engWrEn = 1'b1;
                    engWrData[DESC_OWN_BIT]   = 1'b0;
                    engWrData[DESC_START_BIT] = 1'b0;
                    engWrData[DESC_END_BIT]   = 1'b0;
                    curIdx_d = nextIdx;
                end else begin
                    curIdx_d = nextIdx;
                end
            end
            ST_DROP: begin
                if (rxValid && rxLast) begin
                    state_d = ST_RELEASE;
                end
            end
            default: begin
                state_d = ST_SEARCH;
            end
        endcase
    end

    assign rxReady = (state_q == ST_FILL) || (state_q == ST_DROP);

    // Engine state registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q  <= ST_SEARCH;
            curIdx_q <= '0;
            cnt_q    <= '0;
            endF_q   <= 1'b0;
            errF_q   <= 1'b0;
            frames_q <= FRAMES_RESET;
        end else begin
            state_q  <= state_d;
            curIdx_q <= curIdx_d;
            cnt_q    <= cnt_d;
            endF_q   <= endF_d;
            errF_q   <= errF_d;
            frames_q <= frames_d;
        end
    end

    // Buffer byte writes toward memory
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bufWrValid  <= 1'b0;
            bufWrIdx    <= '0;
            bufWrOffset <= '0;
            bufWrData   <= 8'h00;
        end else begin
            bufWrValid  <= (state_q == ST_FILL) && rxValid;
            bufWrIdx    <= curIdx_q;
            bufWrOffset <= cnt_q;
            bufWrData   <= rxData;
        end
    end

endmodule

/* File: verification/lookahead_rx_properties.sv */
// Port-level checks of the look-ahead receive engine
`timescale 1ns/1ps
module lookahead_rx_properties
    import lookahead_rx_pkg::*;
(
    input wire logic                       clk,
    input wire logic                       rst_n,
    input wire logic                       rxValid,
    input wire logic [7:0]                 rxData,
    input wire logic                       rxLast,
    input wire logic                       rxReady,
    input wire logic                       bufWrValid,
    input wire lookahead_rx_pkg::ringIdx_t bufWrIdx,
    input wire lookahead_rx_pkg::bufCnt_t  bufWrOffset,
    input wire logic [7:0]                 bufWrData,
    input wire logic                       hreadyout,
    input wire logic                       hresp
);
    // ************************************************************
    // Last written buffer position
    // ************************************************************
    ringIdx_t lastIdx_q;
    bufCnt_t  lastOff_q;

    // Remember where the previous byte went
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lastIdx_q <= '0;
            lastOff_q <= '0;
        end else if (bufWrValid) begin
            lastIdx_q <= bufWrIdx;
            lastOff_q <= bufWrOffset;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence byteTaken;
        rxValid && rxReady;
    endsequence
    sequence lastTaken;
        rxValid && rxReady && rxLast;
    endsequence
    // Bytes swallowed after an overflow are taken but never written
    sequence lastWritten;
        lastTaken ##1 bufWrValid;
    endsequence

    byte_forward_a: assert property (bufWrValid |-> bufWrData == $past(rxData))
        else $error("buffer byte differs from accepted byte");
    no_spurious_a: assert property (!rxReady |=> !bufWrValid)
        else $error("buffer write without accepted byte");
    offset_chain_a: assert property (bufWrValid && bufWrOffset != 0 |->
        bufWrIdx == lastIdx_q && bufWrOffset == lastOff_q + 1'b1)
        else $error("buffer offset out of order");
    last_close_a: assert property (lastTaken |=> !rxReady)
        else $error("stream open after frame end");
    last_pulse_a: assert property (lastWritten |=> !bufWrValid)
        else $error("final byte write malformed");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    reset_idle_a: assert property ($rose(rst_n) |-> !rxReady && !bufWrValid)
        else $error("engine active right after reset");
    write_cause_a: assert property (bufWrValid |-> $past(rxValid && rxReady))
        else $error("buffer write without cause");
endmodule

bind lookahead_rx_engine lookahead_rx_properties u_props (.clk(clk), .rst_n(rst_n),
    .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast), .rxReady(rxReady),
    .bufWrValid(bufWrValid), .bufWrIdx(bufWrIdx), .bufWrOffset(bufWrOffset),
    .bufWrData(bufWrData), .hreadyout(hreadyout), .hresp(hresp));

/* File: verification/rx_frame_source.sv */
// Receive byte source standing in for the network side
`timescale 1ns/1ps
module rx_frame_source (
    input  wire logic       clk,
    input  wire logic       rxReady,
    output logic            rxValid,
    output logic [7:0]      rxData,
    output logic            rxLast,
    output logic            rxErr
);
    initial begin
        rxValid = 1'b0;
        rxData  = 8'h00;
        rxLast  = 1'b0;
        rxErr   = 1'b0;
    end

    // Offer one frame, each byte held until taken
    task automatic send(input int len, input logic err);
        logic ok;
        for (int i = 0; i < len; i++) begin
            rxValid <= 1'b1;
            rxData  <= i[7:0] ^ 8'hA5;
            rxLast  <= (i == len - 1);
            rxErr   <= err && (i == len - 1);
            do begin
                @(negedge clk);
                ok = rxReady;
                @(posedge clk);
            end while (!ok);
        end
        rxValid <= 1'b0;
        rxLast  <= 1'b0;
        rxErr   <= 1'b0;
        rxData  <= ~rxData;    // No stale byte once released
    endtask
endmodule

/* File: verification/tb_lookahead_rx_descriptor_chain.sv */
// Self-checking bench of the look-ahead receive engine
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
    $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb_lookahead_rx_descriptor_chain;
    import lookahead_rx_pkg::*;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic        hreadyout, hresp, rxValid, rxLast, rxErr, rxReady;
    logic [7:0]  rxData;
    int          miscompares = 0, checked = 0;

    always #20 clk = ~clk;

    lookahead_rx_engine dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .rxValid(rxValid), .rxData(rxData), .rxLast(rxLast), .rxErr(rxErr),
        .rxReady(rxReady), .bufWrValid(), .bufWrIdx(), .bufWrOffset(), .bufWrData());
    rx_frame_source src (.clk(clk), .rxReady(rxReady), .rxValid(rxValid),
        .rxData(rxData), .rxLast(rxLast), .rxErr(rxErr));

    // Single AHB-Lite transfer, both phases held until hready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0000_0000, r);
        `CHK(r, e)
    endtask
    function automatic logic [7:0] da(input int i);
        return REG_DESC_BASE + 8'(i * 4);
    endfunction
    function automatic descWord_t dw(input logic o, s, e, r, input bufCnt_t n);
        return {o, s, e, r, 17'h0_0000, n};
    endfunction
    // Group of three: owned start, owned middle, third with stale end flag
    task automatic grp(input int g, input logic thirdOwn);
        wr(da(3 * g), dw(1'b1, 1'b1, 1'b0, 1'b0, 11'h320));
        wr(da(3 * g + 1), dw(1'b1, 1'b0, 1'b0, 1'b0, 11'h0C8));
        wr(da(3 * g + 2), dw(thirdOwn, 1'b0, 1'b1, 1'b0, 11'h0C8));
    endtask
    task automatic tally_and_finish();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdchk(REG_CTRL_OFS, 32'h0000_0000);
        rdchk(da(4), 32'h0000_0000);
        grp(0, 1'b1);
        grp(1, 1'b0);
        grp(2, 1'b1);
        wr(REG_CTRL_OFS, 32'h0000_0001);
        rdchk(REG_CTRL_OFS, 32'h0000_0001);
        rdchk(8'h20, 32'h0000_0000);
        src.send(1060, 1'b0);
        repeat (10) @(posedge clk);
        rdchk(da(0), dw(1'b0, 1'b1, 1'b0, 1'b0, 11'h320));
        rdchk(da(1), dw(1'b0, 1'b0, 1'b0, 1'b0, 11'h0C8));
        rdchk(da(2), dw(1'b0, 1'b0, 1'b1, 1'b0, 11'h0C8));
        rdchk(da(3), dw(1'b1, 1'b1, 1'b0, 1'b0, 11'h320));
        rdchk(REG_STATUS_OFS, 32'h0001_0203);
        src.send(900, 1'b0);
        repeat (10) @(posedge clk);
        rdchk(da(4), dw(1'b0, 1'b0, 1'b1, 1'b0, 11'h0C8));
        rdchk(da(5), dw(1'b0, 1'b0, 1'b1, 1'b0, 11'h0C8));
        // Host skips the stale end flag and finds the next start descriptor
        rdchk(da(6), dw(1'b1, 1'b1, 1'b0, 1'b0, 11'h320));
        src.send(900, 1'b1);
        repeat (10) @(posedge clk);
        rdchk(da(7), dw(1'b0, 1'b0, 1'b0, 1'b1, 11'h0C8));
        rdchk(da(8), dw(1'b0, 1'b0, 1'b0, 1'b0, 11'h0C8));
        grp(0, 1'b0);
        src.send(100, 1'b0);
        repeat (10) @(posedge clk);
        rdchk(da(0), dw(1'b0, 1'b1, 1'b1, 1'b0, 11'h320));
        rdchk(da(1), dw(1'b0, 1'b0, 1'b0, 1'b0, 11'h0C8));
        rdchk(da(2), dw(1'b0, 1'b0, 1'b1, 1'b0, 11'h0C8));
        // Search walk: owned middle, unowned middle, parked start
        wr(da(3), dw(1'b1, 1'b0, 1'b0, 1'b0, 11'h0C8));
        wr(da(4), dw(1'b0, 1'b0, 1'b0, 1'b0, 11'h0C8));
        wr(da(5), dw(1'b0, 1'b0, 1'b1, 1'b0, 11'h0C8));
        wr(da(6), dw(1'b0, 1'b1, 1'b0, 1'b0, 11'h320));
        fork
            src.send(100, 1'b0);
        join_none
        repeat (20) @(posedge clk);
        rdchk(REG_STATUS_OFS, 32'h0004_0106);
        rdchk(da(3), dw(1'b0, 1'b0, 1'b0, 1'b0, 11'h0C8));
        rdchk(da(5), dw(1'b0, 1'b0, 1'b1, 1'b0, 11'h0C8));
        wr(da(7), dw(1'b1, 1'b0, 1'b0, 1'b0, 11'h0C8));
        wr(da(6), dw(1'b1, 1'b1, 1'b0, 1'b0, 11'h320));
        wait fork;
        repeat (10) @(posedge clk);
        rdchk(da(6), dw(1'b0, 1'b1, 1'b1, 1'b0, 11'h320));
        rdchk(da(7), dw(1'b0, 1'b0, 1'b0, 1'b0, 11'h0C8));
        // Overflow: third not owned, second marked in error, rest dropped
        grp(0, 1'b0);
        src.send(1100, 1'b0);
        repeat (10) @(posedge clk);
        rdchk(da(0), dw(1'b0, 1'b1, 1'b0, 1'b0, 11'h320));
        rdchk(da(1), dw(1'b0, 1'b0, 1'b0, 1'b1, 11'h0C8));
        rdchk(da(2), dw(1'b0, 1'b0, 1'b1, 1'b0, 11'h0C8));
        rdchk(REG_STATUS_OFS, 32'h0006_0106);
        tally_and_finish();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end
endmodule
